//--- rtl/vsf_pkg.sv
package vsf_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 20;
    localparam int MASK_TIME_US    = 150;
    localparam int MASK_CYCLES     = (MASK_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int CLOCK_ENABLE_OUT_TIME_US   = 60;
    localparam int CLOCK_ENABLE_OUT_CYCLES    = (CLOCK_ENABLE_OUT_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int PGOOD_TIME_MS   = 5;
    localparam int PGOOD_CYCLES    = (PGOOD_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam int CNT_W           = 18;

    // ------------------------------------------------------------
    // Slew rate division during soft-start and soft-shutdown
    // ------------------------------------------------------------
    localparam logic [1:0] SOFT_DIV_LAST = 2'h3;

    // ------------------------------------------------------------
    // Target codes, 12.5 mV per step
    // ------------------------------------------------------------
    localparam int          CODE_W     = 8;
    localparam logic [7:0]  BOOT_CODE  = 8'h58;
    localparam logic [7:0]  FLOOR_CODE = 8'h01;
    localparam logic [7:0]  ZERO_CODE  = 8'h00;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        VSF_OFF   = 3'b000,
        VSF_REF   = 3'b001,
        VSF_MASK  = 3'b011,
        VSF_BOOT  = 3'b010,
        VSF_CLKW  = 3'b110,
        VSF_RUN   = 3'b111,
        VSF_CHIP_ENABLE_PIN  = 3'b101
    } vsf_state_t;

endpackage : vsf_pkg

//--- rtl/vsf_sequencer.sv
// What this block does
// R1 - Reference first, then 150us mask, then switching
// R2 - Power-on reset clears fault latch
// R3 - Hold off until supply, system, enable
// R4 - Soft-start ramp to boot at quarter rate
// R5 - 60us after boot: clock enable, full slew
// R6 - Power good released 5ms after clock enable
// R7 - Skip in soft-start, forced PWM in shutdown
// R8 - Supply loss: all gates low, discharge on; a latched overvoltage clamp keeps its low gates on and discharge off
// R9 - Enable low: power good low, slow ramp
// R10 - At 12.5mV complete shutdown, outputs safe
// R11 - Fault latch blocks restart until toggled
// R12 - Overvoltage above target or fixed level
// R13 - Skip mode uses fixed level until regulating
// R14 - Multiphase overvoltage: all low gates high
// R15 - Single-phase overvoltage drives phase one only
// R16 - Undervoltage starts shutdown, sets latch
// R17 - Overtemperature latches, safe gate state
// R18 - Test level disables faults, clears latch
// R19 - High and low gates interlocked per phase
// R20 - Phase shed low disables phase three
// R21 - Deep sleep disables phases two, three; code ignores deep sleep during soft shutdown
// R22 - Synchronised comparators, counted delays
// R23 - Latch holds through ramp, blocks restart
`timescale 1ns/1ps
`default_nettype none

module vsf_sequencer
    import vsf_pkg::*;
(
    input  wire logic              mclk_in,
    input  wire logic              rstn_in,
    input  wire logic              vcc_por_in,
    input  wire logic              vcc_good_in,
    input  wire logic              sys_enable_in,
    input  wire logic              chip_enable_pin_in,
    input  wire logic              test_level_in,
    input  wire logic              ref_good_in,
    input  wire logic              ovp_track_in,
    input  wire logic              ovp_fixed_in,
    input  wire logic              uvp_in,
    input  wire logic              over_temp_in,
    input  wire logic              in_regulation_in,
    input  wire logic              output_low_in,
    input  wire logic              deep_sleep_select_in,
    input  wire logic              phase_shed_select_in,
    input  wire logic              slew_tick_in,
    input  wire logic [7:0]        voltage_code_in,
    input  wire logic              pwm1_in,
    input  wire logic              pwm2_in,
    input  wire logic              third_phase_pwm_in,
    input  wire logic              phase1_high_off_in,
    input  wire logic              phase1_low_off_in,
    input  wire logic              phase2_high_off_in,
    input  wire logic              phase2_low_off_in,
    output logic                   ref_enable_out,
    output logic                   switching_out,
    output logic                   skip_mode_out,
    output logic [7:0]             target_code_out,
    output logic                   clock_enable_out,
    output logic                   power_good_out,
    output logic                   power_good_oe_out,
    output logic                   phase1_high_gate_out,
    output logic                   phase1_low_gate_out,
    output logic                   phase2_high_gate_out,
    output logic                   phase2_low_gate_out,
    output logic                   third_phase_pwm_out,
    output logic                   third_phase_pwm_oe_out,
    output logic                   external_skip_line_out,
    output logic                   output_discharge_node_out,
    output logic                   fault_latched_out
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 22;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;

    assign raw_in = {vcc_por_in, vcc_good_in, sys_enable_in, chip_enable_pin_in,
                     test_level_in, ref_good_in, ovp_track_in, ovp_fixed_in, uvp_in,
                     over_temp_in, in_regulation_in, output_low_in,
                     deep_sleep_select_in, phase_shed_select_in, slew_tick_in,
                     pwm1_in, pwm2_in, third_phase_pwm_in, phase1_high_off_in,
                     phase1_low_off_in, phase2_high_off_in, phase2_low_off_in};

    // R22 two-stage synchronisers
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end

    logic s_por, s_vcc, s_sys, s_en, s_test, s_ref, s_ovt, s_ovf, s_uv, s_ot;
    logic s_reg, s_low, s_dslp, s_psi, s_tick, s_p1, s_p2, s_p3;
    logic s_h1off, s_l1off, s_h2off, s_l2off;
    assign {s_por, s_vcc, s_sys, s_en, s_test, s_ref, s_ovt, s_ovf, s_uv, s_ot,
            s_reg, s_low, s_dslp, s_psi, s_tick, s_p1, s_p2, s_p3,
            s_h1off, s_l1off, s_h2off, s_l2off} = sync2_reg;

    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    vsf_state_t       state_reg;
    vsf_state_t       state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [7:0]       target_reg;
    logic [7:0]       target_next;
    logic [1:0]       div_reg;
    logic             fault_reg;
    logic             fault_next;
    logic             en_d_reg;
    logic             por_d_reg;
    logic             pgood_rel_reg;
    logic             pgood_rel_next;
    logic             ovp_hit_reg;
    logic             ovp_multi_reg;

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    // R3 all three conditions together
    wire start_ok   = s_vcc && s_sys && s_en;
    // R18 test level masks protection
    wire prot_on    = !s_test;
    wire en_toggle  = en_d_reg && !s_en;
    // R2 power-on reset edge
    wire por_rise   = s_por && !por_d_reg;
    wire soft_phase = (state_reg == VSF_BOOT) || (state_reg == VSF_CHIP_ENABLE_PIN);
    // R4 quarter rate during soft ramps
    wire soft_step  = s_tick && (div_reg == SOFT_DIV_LAST);
    wire step_en    = soft_phase ? soft_step : s_tick;
    wire skip_sel   = (state_reg == VSF_BOOT) ? 1'b1 :
                      (state_reg == VSF_CHIP_ENABLE_PIN) ? 1'b0 : s_dslp;
    // R13 fixed threshold until regulating in skip mode
    wire ovp_level  = (skip_sel && !s_reg) ? s_ovf : (s_ovt || s_ovf);
    // R12 overvoltage detect
    wire ovp_evt    = prot_on && ovp_level && switching_out;
    // R16 undervoltage detect
    wire uvp_evt    = prot_on && s_uv && (state_reg == VSF_RUN);
    // R17 thermal detect
    wire ot_evt     = prot_on && s_ot;
    // R14 multiphase selects the full clamp
    wire multi_mode = !s_dslp && s_psi;
    wire cnt_done   = (cnt_reg == '0);
    wire at_boot    = (target_reg == BOOT_CODE);
    wire at_floor   = (target_reg <= FLOOR_CODE);

    function automatic logic [7:0] step_to(input logic [7:0] cur, input logic [7:0] goal);
        if (cur < goal)
            step_to = cur + 8'h01;
        else if (cur > goal)
            step_to = cur - 8'h01;
        else
            step_to = cur;
    endfunction

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        state_next     = state_reg;
        cnt_next       = cnt_done ? cnt_reg : cnt_reg - 1'b1;
        target_next    = target_reg;
        pgood_rel_next = pgood_rel_reg;
        case (state_reg)
            VSF_OFF: begin
                target_next = ZERO_CODE;
                // R23 latch blocks restart
                if (start_ok && !fault_reg)
                    state_next = VSF_REF;
            end
            VSF_REF: begin
                // R1 mask after reference lockout clears
                if (s_ref) begin
                    state_next = VSF_MASK;
                    cnt_next   = CNT_W'(MASK_CYCLES - 1);
                end
            end
            VSF_MASK: begin
                if (cnt_done)
                    state_next = VSF_BOOT;
            end
            VSF_BOOT: begin
                // R4 ramp to boot code
                if (step_en)
                    target_next = step_to(target_reg, BOOT_CODE);
                if (at_boot) begin
                    state_next = VSF_CLKW;
                    cnt_next   = CNT_W'(CLOCK_ENABLE_OUT_CYCLES - 1);
                end
            end
            VSF_CLKW: begin
                // R5 clock enable then full-rate slew
                if (cnt_done) begin
                    state_next = VSF_RUN;
                    cnt_next   = CNT_W'(PGOOD_CYCLES - 1);
                end
            end
            VSF_RUN: begin
                if (step_en)
                    target_next = step_to(target_reg, voltage_code_in);
                // R6 power good release after delay
                if (cnt_done)
                    pgood_rel_next = 1'b1;
            end
            VSF_CHIP_ENABLE_PIN: begin
                // R9 slow ramp down
                if (step_en)
                    target_next = step_to(target_reg, ZERO_CODE);
                // R10 complete at lowest step
                if (at_floor && s_low)
                    state_next = VSF_OFF;
            end
            default: state_next = VSF_OFF;
        endcase
        // R9 enable low starts soft shutdown
        // R16 undervoltage starts soft shutdown
        if (state_reg != VSF_OFF && state_reg != VSF_CHIP_ENABLE_PIN && (!s_en || uvp_evt)) begin
            state_next     = VSF_CHIP_ENABLE_PIN;
            pgood_rel_next = 1'b0;
        end
        // R8 supply loss stops at once
        if (!s_vcc || ot_evt) begin
            state_next = VSF_OFF;
            target_next = ZERO_CODE;
        end
        if (state_next == VSF_OFF || state_next == VSF_CHIP_ENABLE_PIN)
            pgood_rel_next = 1'b0;
    end

    // ------------------------------------------------------------
    // Fault latch
    // ------------------------------------------------------------
    always_comb begin
        fault_next = fault_reg;
        // R11 cleared by toggle or supply cycle
        if (en_toggle || por_rise || s_test)
            fault_next = 1'b0;
        // R11 fault events set, set wins
        if (ovp_evt || uvp_evt || ot_evt)
            fault_next = 1'b1;
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            state_reg     <= VSF_OFF;
            cnt_reg       <= '0;
            target_reg    <= ZERO_CODE;
            div_reg       <= 2'h0;
            fault_reg     <= 1'b0;
            en_d_reg      <= 1'b0;
            por_d_reg     <= 1'b0;
            pgood_rel_reg <= 1'b0;
            ovp_hit_reg   <= 1'b0;
            ovp_multi_reg <= 1'b0;
        end else begin
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            target_reg    <= target_next;
            div_reg       <= s_tick ? div_reg + 2'h1 : div_reg;
            fault_reg     <= fault_next;
            en_d_reg      <= s_en;
            por_d_reg     <= s_por;
            pgood_rel_reg <= pgood_rel_next;
            // R14 clamp holds with the latch
            if (ovp_evt && !ovp_hit_reg) begin
                ovp_hit_reg   <= 1'b1;
                ovp_multi_reg <= multi_mode;
            end else if (!fault_next) begin
                ovp_hit_reg   <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Gate drive selection
    // ------------------------------------------------------------
    wire run_on   = (state_reg == VSF_BOOT) || (state_reg == VSF_CLKW) ||
                    (state_reg == VSF_RUN) || (state_reg == VSF_CHIP_ENABLE_PIN);
    // R21 deep sleep drops phases two and three outside soft shutdown
    wire ph2_on   = run_on && !(skip_sel && s_dslp);
    // R20 phase shed drops phase three
    wire ph3_on   = ph2_on && s_psi;
    // R19 each switch waits for the other off
    logic [3:0] g1_reg, g2_reg, g3_reg;
    wire  [3:0] g_now = {phase2_low_gate_out, phase2_high_gate_out, phase1_low_gate_out,
                         phase1_high_gate_out};
    wire  [3:0] quiet = ~(g_now | g1_reg | g2_reg | g3_reg);
    wire h1_want  = run_on && s_p1 && s_l1off && quiet[1];
    wire l1_want  = run_on && !s_p1 && s_h1off && quiet[0];
    wire h2_want  = ph2_on && s_p2 && s_l2off && quiet[3];
    wire l2_want  = ph2_on && !s_p2 && !skip_sel && s_h2off && quiet[2];
    wire ovp_act  = ovp_hit_reg && fault_reg;
    // R14 multiphase clamp
    wire ovp_all  = ovp_act && ovp_multi_reg;
    // R15 single-phase clamp
    wire ovp_one  = ovp_act && !ovp_multi_reg;
    wire dh1_n    = ovp_act ? 1'b0 : h1_want;
    wire dl1_n    = ovp_act ? (s_h1off && quiet[0]) : l1_want;
    wire dh2_n    = ovp_act ? 1'b0 : h2_want;
    wire dl2_n    = ovp_all ? (s_h2off && quiet[2]) : (ovp_one ? 1'b0 : l2_want);
    wire p3_n     = ovp_all ? 1'b0 : s_p3;
    wire p3oe_n   = ovp_all || ph3_on;
    wire skp_n    = ovp_all || (ph3_on && !ovp_act);
    // R8 R10 R17 discharge while off and no overvoltage clamp active
    wire dis_n    = (state_reg == VSF_OFF) && !ovp_act;

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            ref_enable_out            <= 1'b0;
            switching_out             <= 1'b0;
            skip_mode_out             <= 1'b0;
            target_code_out           <= ZERO_CODE;
            clock_enable_out          <= 1'b1;
            power_good_out            <= 1'b0;
            power_good_oe_out         <= 1'b1;
            phase1_high_gate_out      <= 1'b0;
            phase1_low_gate_out       <= 1'b0;
            phase2_high_gate_out      <= 1'b0;
            phase2_low_gate_out       <= 1'b0;
            third_phase_pwm_out       <= 1'b0;
            third_phase_pwm_oe_out    <= 1'b0;
            external_skip_line_out    <= 1'b0;
            output_discharge_node_out <= 1'b1;
            fault_latched_out         <= 1'b0;
            {g3_reg, g2_reg, g1_reg}  <= '0;
        end else begin
            ref_enable_out            <= state_next != VSF_OFF;
            switching_out             <= run_on && (state_next != VSF_OFF);
            // R7 skip in soft-start, forced PWM in shutdown
            skip_mode_out             <= skip_sel;
            target_code_out           <= target_reg;
            clock_enable_out          <= !(state_reg == VSF_RUN);
            power_good_out            <= 1'b0;
            power_good_oe_out         <= !pgood_rel_reg;
            phase1_high_gate_out      <= dh1_n;
            phase1_low_gate_out       <= dl1_n;
            phase2_high_gate_out      <= dh2_n;
            phase2_low_gate_out       <= dl2_n;
            third_phase_pwm_out       <= p3_n;
            third_phase_pwm_oe_out    <= p3oe_n;
            external_skip_line_out    <= skp_n;
            output_discharge_node_out <= dis_n;
            fault_latched_out         <= fault_reg;
            {g3_reg, g2_reg, g1_reg}  <= {g2_reg, g1_reg, g_now};
        end
    end

endmodule // vsf_sequencer

`default_nettype wire

//--- sim/vsf_gate_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Gate driver model with sensed-off feedback
// ------------------------------------------------------------
module vsf_gate_model (
    input  wire logic       mclk_in,
    input  wire logic       slow_in,
    input  wire logic [3:0] gate_in,
    output logic      [3:0] off_out
);
    logic [3:0] h0_reg = 4'h0;
    logic [3:0] h1_reg = 4'h0;
    logic [3:0] h2_reg = 4'h0;

    always_ff @(posedge mclk_in) begin
        h0_reg <= gate_in;
        h1_reg <= h0_reg;
        h2_reg <= h1_reg;
    end

    assign off_out = ~(gate_in | h0_reg | (slow_in ? (h1_reg | h2_reg) : 4'h0));
endmodule // vsf_gate_model

`default_nettype wire

//--- sim/vsf_sequencer_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module vsf_chk (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic vcc_good_in,
    input wire logic test_level_in,
    input wire logic ovp_track_in,
    input wire logic deep_sleep_select_in,
    input wire logic phase_shed_select_in,
    input wire logic ref_enable_out,
    input wire logic switching_out,
    input wire logic clock_enable_out,
    input wire logic power_good_oe_out,
    input wire logic phase1_high_gate_out,
    input wire logic phase1_low_gate_out,
    input wire logic phase2_high_gate_out,
    input wire logic phase2_low_gate_out,
    input wire logic third_phase_pwm_oe_out,
    input wire logic external_skip_line_out,
    input wire logic output_discharge_node_out,
    input wire logic fault_latched_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    chk_gate_overlap: assert property (!(phase1_high_gate_out && phase1_low_gate_out)
        && !(phase2_high_gate_out && phase2_low_gate_out))
        else $error("high and low gate on together");
    chk_dead_time: assert property ($rose(phase2_high_gate_out)
        |-> $past(!phase2_low_gate_out, 2)) else $error("high gate rose without dead time");
    chk_pgood_order: assert property (!power_good_oe_out |-> !clock_enable_out)
        else $error("power good released before clock enable");
    chk_switch_ref: assert property (switching_out |-> ref_enable_out)
        else $error("switching without reference");
    chk_reset_safe: assert property (disable iff (1'b0) !rstn_in |=> output_discharge_node_out
        && clock_enable_out && power_good_oe_out && !third_phase_pwm_oe_out
        && !phase1_high_gate_out && !phase1_low_gate_out) else $error("reset state not safe");
    chk_supply_loss: assert property ($fell(vcc_good_in) |-> ##[1:5] (output_discharge_node_out
        && !phase1_high_gate_out && !phase1_low_gate_out && !phase2_high_gate_out
        && !phase2_low_gate_out)) else $error("supply loss did not shut down");
    chk_shed_phase: assert property ($fell(phase_shed_select_in) |-> ##[1:5]
        (!third_phase_pwm_oe_out && !external_skip_line_out)) else $error("phase three kept");
    chk_sleep_phases: assert property (deep_sleep_select_in [*5] |-> !phase2_high_gate_out
        && !phase2_low_gate_out && !third_phase_pwm_oe_out) else $error("deep sleep phases on");
    chk_test_latch: assert property (test_level_in [*5] |-> !fault_latched_out)
        else $error("test level left latch set");
    chk_ovp_clamp: assert property ($rose(ovp_track_in) && switching_out && vcc_good_in
        && !test_level_in && !deep_sleep_select_in && phase_shed_select_in |-> ##[2:10]
        (phase1_low_gate_out && phase2_low_gate_out && !phase1_high_gate_out
        && !phase2_high_gate_out && external_skip_line_out && fault_latched_out))
        else $error("multiphase overvoltage clamp missing");
endmodule // vsf_chk

`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import vsf_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        mclk_in = 1'b0, rstn_in, vcc_por_in, vcc_good_in, sys_enable_in, uvp_in;
    logic        chip_enable_pin_in, test_level_in, ref_good_in, ovp_track_in, ovp_fixed_in;
    logic        over_temp_in, in_regulation_in, output_low_in, slew_tick_in, slow_sense;
    logic        deep_sleep_select_in, phase_shed_select_in, pwm1_in, pwm2_in, third_phase_pwm_in;
    logic [7:0]  voltage_code_in, target_code_out;
    logic        ref_enable_out, switching_out, skip_mode_out, clock_enable_out, power_good_out;
    logic        power_good_oe_out, phase1_high_gate_out, phase1_low_gate_out;
    logic        phase2_high_gate_out, phase2_low_gate_out, third_phase_pwm_out;
    logic        third_phase_pwm_oe_out, external_skip_line_out, output_discharge_node_out;
    logic        fault_latched_out;
    wire  [3:0]  off_sense;
    wire         phase1_high_off_in = off_sense[0];
    wire         phase1_low_off_in  = off_sense[1];
    wire         phase2_high_off_in = off_sense[2];
    wire         phase2_low_off_in  = off_sense[3];
    int          err_total = 0, n_checks = 0, seed = 91;
    logic [31:0] rnd;
    typedef struct { string name; logic [21:0] mask; logic [21:0] val; } vsf_note_t;
    vsf_note_t   note_q[$];
    vsf_note_t   cur;
    localparam logic [21:0] SAFE_M = 22'h1de0;
    localparam logic [21:0] SAFE_V = 22'h1000;
    localparam logic [21:0] TGT_M  = 22'h3fc000;
    wire  [21:0] obs = {target_code_out, fault_latched_out, output_discharge_node_out,
        external_skip_line_out, third_phase_pwm_oe_out, third_phase_pwm_out, phase2_low_gate_out,
        phase2_high_gate_out, phase1_low_gate_out, phase1_high_gate_out, power_good_oe_out,
        clock_enable_out, skip_mode_out, switching_out, ref_enable_out};

    vsf_sequencer u_vsf_sequencer (.*);
    vsf_gate_model u_vsf_gate_model (.mclk_in(mclk_in), .slow_in(slow_sense), .off_out(off_sense),
        .gate_in({phase2_low_gate_out, phase2_high_gate_out, phase1_low_gate_out,
        phase1_high_gate_out}));

    always #10 mclk_in = ~mclk_in;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic hold(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    task automatic note(input string nm, input logic [21:0] m, input logic [21:0] v);
        note_q.push_back('{nm, m, v});
    endtask
    task automatic wait_on(input string nm, input logic [21:0] m, input logic [21:0] v, int lim);
        for (int i = 0; i < lim && (obs & m) !== v; i++) @(posedge mclk_in);
        note(nm, m, v);
    endtask
    task automatic bring_up;
        wait_on("switching", 22'h2, 22'h2, 8000);
        wait_on("boot", TGT_M, {BOOT_CODE, 14'h0}, 600);
        wait_on("clock_enable_out", 22'h8, 22'h0, 3500);
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Monitor, noise and watchdog
    // ------------------------------------------------------------
    always @(negedge mclk_in) begin
        while (note_q.size() > 0) begin
            cur = note_q.pop_front();
            n_checks++;
            if ((obs & cur.mask) !== cur.val) begin
                err_total++;
                $display("BAD %s expected %h seen %h", cur.name, cur.val, obs & cur.mask);
            end
        end
    end
    always @(posedge mclk_in) begin
        rnd = $random(seed);
        {pwm1_in, pwm2_in, third_phase_pwm_in, slow_sense} <= rnd[3:0];
    end
    initial begin
        hold(95000);
        err_total++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rstn_in, sys_enable_in, chip_enable_pin_in, test_level_in, ref_good_in} = 5'h0;
        {ovp_track_in, ovp_fixed_in, uvp_in, over_temp_in, in_regulation_in} = 5'h0;
        {output_low_in, deep_sleep_select_in, pwm1_in, pwm2_in, third_phase_pwm_in, slow_sense} = 6'h0;
        {vcc_por_in, vcc_good_in, phase_shed_select_in, slew_tick_in} = 4'hf;
        rnd = $random(seed);
        voltage_code_in = 8'h60 | {3'h0, rnd[4:0]};
        hold(5);
        rstn_in <= 1'b1;
        note("reset", SAFE_M | TGT_M | 22'h18, SAFE_V | 22'h18);
        chip_enable_pin_in <= 1'b1;
        hold(50);
        note("refused", 22'h3, 22'h0);
        sys_enable_in <= 1'b1;
        wait_on("reference", 22'h1, 22'h1, 10);
        ref_good_in <= 1'b1;
        hold(7400);
        note("masked", 22'h2, 22'h0);
        wait_on("switching", 22'h6, 22'h6, 300);
        hold(200);
        note("quarter", 22'h100000, 22'h0);
        wait_on("boot", TGT_M, {BOOT_CODE, 14'h0}, 300);
        hold(2900);
        note("clock_enable_out wait", 22'h8, 22'h8);
        wait_on("clock_enable_out", 22'h8, 22'h0, 300);
        in_regulation_in <= 1'b1;
        wait_on("slew", TGT_M | 22'h10, {voltage_code_in, 14'h10}, 400);
        phase_shed_select_in <= 1'b0;
        hold(8);
        note("shed", 22'hc00, 22'h0);
        phase_shed_select_in <= 1'b1;
        hold(8);
        note("unshed", 22'h400, 22'h400);
        deep_sleep_select_in <= 1'b1;
        hold(8);
        note("sleep", 22'h584, 22'h4);
        deep_sleep_select_in <= 1'b0;
        chip_enable_pin_in <= 1'b0;
        hold(8);
        note("soft stop", 22'h14, 22'h10);
        output_low_in <= 1'b1;
        wait_on("off", SAFE_M | 22'h2001, SAFE_V, 800);
        output_low_in <= 1'b0;
        chip_enable_pin_in <= 1'b1;
        bring_up();
        ovp_track_in <= 1'b1;
        hold(12);
        note("ovp multi", 22'h2fe0, 22'h2d40);
        ovp_track_in <= 1'b0;
        hold(8);
        note("ovp held", 22'h2fe0, 22'h2d40);
        {chip_enable_pin_in, output_low_in} <= 2'h1;
        hold(8);
        note("toggle clear", 22'h2000, 22'h0);
        wait_on("stopped", SAFE_M, SAFE_V, 800);
        {chip_enable_pin_in, output_low_in} <= 2'h2;
        bring_up();
        phase_shed_select_in <= 1'b0;
        hold(8);
        ovp_track_in <= 1'b1;
        hold(12);
        note("ovp single", 22'h21e0, 22'h2040);
        {ovp_track_in, chip_enable_pin_in, output_low_in} <= 3'h1;
        wait_on("ovp stop", SAFE_M, SAFE_V, 800);
        {phase_shed_select_in, chip_enable_pin_in, output_low_in} <= 3'h6;
        bring_up();
        uvp_in <= 1'b1;
        hold(8);
        note("uvp", 22'h2014, 22'h2010);
        {uvp_in, output_low_in} <= 2'h1;
        wait_on("uvp off", SAFE_M, SAFE_V, 800);
        hold(50);
        note("blocked", 22'h2001, 22'h2000);
        test_level_in <= 1'b1;
        hold(8);
        note("test clear", 22'h2000, 22'h0);
        {test_level_in, output_low_in} <= 2'h0;
        wait_on("switching", 22'h2, 22'h2, 8000);
        over_temp_in <= 1'b1;
        hold(8);
        note("thermal", SAFE_M | 22'h2000, SAFE_V | 22'h2000);
        over_temp_in <= 1'b0;
        hold(20);
        vcc_por_in <= 1'b0;
        hold(4);
        vcc_por_in <= 1'b1;
        hold(8);
        note("por clear", 22'h2000, 22'h0);
        wait_on("switching", 22'h2, 22'h2, 8000);
        vcc_good_in <= 1'b0;
        hold(8);
        note("supply loss", SAFE_M, SAFE_V);
        hold(2);
        print_verdict();
    end
endmodule // tb_top

bind vsf_sequencer vsf_chk u_vsf_chk (.*);

`default_nettype wire
